// ==== design/kpd_debounce.sv ====
// top: keypad debounce and hold timing, per-key mask, pin reuse as GPIO,
// all settings reached over an AXI4-Lite slave.
// assumes key_raw is already a synchronous per-key pressed level.
// Behaviour
// - debounce code picks 2 to 120 ms interval
// - hold code zero waits 100 us between scans
// - hold code N waits N debounce intervals
// - mask register at write 0x0050, read 0x8050
// - mask bit 4*(col-1)+(row-1) covers one key
// - masked keys never change stored key state
// - rows and columns may serve as GPIO pins
// - control bits 13:11 debounce, 10:8 hold
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module kpd_debounce #(
	parameter int unsigned CYC_PER_MS = kpd_pkg::CLK_PER_MS
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire kpd_pkg::axil_req_s axil_req,
	output kpd_pkg::axil_rsp_s     axil_rsp,
	input  wire logic [15:0]       key_raw,
	input  wire logic [7:0]        pad_in,
	output logic      [7:0]        pad_out,
	output logic      [7:0]        pad_oe_n,
	output logic      [7:0]        pullup_en,
	output logic      [15:0]       key_state
);
	import kpd_pkg::*;

	if (CYC_PER_MS < 1 || CYC_PER_MS > 1_000_000) begin : g_chk
		$error("CYC_PER_MS out of range");
	end

	// row r (0..3) is pin r, column c (0..3) is pin 4+c
	function automatic logic [15:0] key_pin_en(input logic [7:0] gp);
		logic [15:0] en;
		en = 16'h0000;
		for (int k = 0; k < 16; k++) begin
			en[k] = ~gp[k % 4] & ~gp[4 + k / 4];
		end
		return en;
	endfunction

	function automatic logic [31:0] dbn_cyc(input logic [2:0] code);
		return 32'(DBN_MS[code] * CYC_PER_MS);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic addr_ok(input logic [11:0] a);
		return a[1:0] == 2'h0 && a[11:10] == 2'h0;
	endfunction

	axil_rsp_s    rsp_r, rsp_nxt;
	logic         aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [11:0]  aw_addr_r, aw_addr_nxt;
	logic [31:0]  wd_r, wd_nxt;
	logic [3:0]   ws_r, ws_nxt;
	logic [2:0]   dbn_r, dbn_nxt, hld_r, hld_nxt;
	logic [15:0]  mask_r, mask_nxt, gpio_ctrl_r, gpio_ctrl_nxt, ctrl_v;
	logic [7:0]   pullup_dis_r, pullup_dis_nxt, gpio_out_r, gpio_out_nxt;
	logic [7:0]   pad_out_r, pad_out_nxt, pad_oe_n_r, pad_oe_n_nxt;
	logic [7:0]   pullup_en_r, pullup_en_nxt;
	logic [15:0]  aw_cmd, ar_cmd;
	scan_e        state_r, state_nxt;
	logic [31:0]  cnt_r, cnt_nxt;
	logic [2:0]   rep_r, rep_nxt;
	logic [15:0]  key_state_r, key_state_nxt, raw_en, live;

	assign axil_rsp  = rsp_r;
	assign pad_out   = pad_out_r;
	assign pad_oe_n  = pad_oe_n_r;
	assign pullup_en = pullup_en_r;
	assign key_state = key_state_r;

	// address to command word: write is the index, read sets the top bit
	assign aw_cmd = {8'h00, aw_addr_r[9:2]};
	assign ar_cmd = CMD_RD_FLAG | {8'h00, axil_req.araddr[9:2]};
	assign ctrl_v = {|key_state_r, state_r == ST_IDLE, dbn_r, hld_r,
		8'h00};

	// bus slave and registers
	always_comb begin
		rsp_nxt        = rsp_r;
		aw_got_nxt     = aw_got_r;
		w_got_nxt      = w_got_r;
		aw_addr_nxt    = aw_addr_r;
		wd_nxt         = wd_r;
		ws_nxt         = ws_r;
		dbn_nxt        = dbn_r;
		hld_nxt        = hld_r;
		mask_nxt       = mask_r;
		gpio_ctrl_nxt  = gpio_ctrl_r;
		pullup_dis_nxt = pullup_dis_r;
		gpio_out_nxt   = gpio_out_r;
		if (rsp_r.awready && axil_req.awvalid) begin
			aw_got_nxt  = 1'b1;
			aw_addr_nxt = axil_req.awaddr;
		end
		if (rsp_r.wready && axil_req.wvalid) begin
			w_got_nxt = 1'b1;
			wd_nxt    = axil_req.wdata;
			ws_nxt    = axil_req.wstrb;
		end
		if (rsp_r.bvalid && axil_req.bready) begin
			rsp_nxt.bvalid = 1'b0;
		end
		// write only once address and data are both held
		if (aw_got_r && w_got_r && !rsp_r.bvalid) begin
			aw_got_nxt     = 1'b0;
			w_got_nxt      = 1'b0;
			rsp_nxt.bvalid = 1'b1;
			rsp_nxt.bresp  = RESP_OKAY;
			if (!addr_ok(aw_addr_r)) begin
				rsp_nxt.bresp = RESP_SLVERR;
			end else if (aw_cmd == CMD_WR_KEY_MASK) begin
				mask_nxt = merge16(mask_r, wd_r, ws_r);
			end else if (aw_cmd == {8'h00, IDX_KPD_CTRL}) begin
				if (ws_r[1]) begin
					dbn_nxt = wd_r[DBN_LSB +: 3];
					hld_nxt = wd_r[HLD_LSB +: 3];
				end
			end else if (aw_cmd == {8'h00, IDX_GPIO_CTRL}) begin
				gpio_ctrl_nxt = merge16(gpio_ctrl_r, wd_r, ws_r);
			end else if (aw_cmd == {8'h00, IDX_PULLUP}) begin
				if (ws_r[0]) pullup_dis_nxt = wd_r[7:0];
			end else if (aw_cmd == {8'h00, IDX_GPIO_DATA}) begin
				if (ws_r[0]) gpio_out_nxt = wd_r[7:0];
			end else if (aw_cmd != {8'h00, IDX_KEY_STATE}) begin
				rsp_nxt.bresp = RESP_SLVERR;
			end
		end
		if (rsp_r.rvalid && axil_req.rready) begin
			rsp_nxt.rvalid = 1'b0;
		end
		if (rsp_r.arready && axil_req.arvalid) begin
			rsp_nxt.rvalid = 1'b1;
			rsp_nxt.rresp  = RESP_OKAY;
			rsp_nxt.rdata  = 32'h0000_0000;
			if (!addr_ok(axil_req.araddr)) begin
				rsp_nxt.rresp = RESP_SLVERR;
			end else if (ar_cmd == CMD_RD_KEY_MASK) begin
				rsp_nxt.rdata = {16'h0000, mask_r};
			end else if (ar_cmd == (CMD_RD_FLAG | {8'h00, IDX_KPD_CTRL})) begin
				rsp_nxt.rdata = {16'h0000, ctrl_v};
			end else if (ar_cmd == (CMD_RD_FLAG | {8'h00, IDX_GPIO_CTRL})) begin
				rsp_nxt.rdata = {16'h0000, gpio_ctrl_r};
			end else if (ar_cmd == (CMD_RD_FLAG | {8'h00, IDX_PULLUP})) begin
				rsp_nxt.rdata = {24'h00_0000, pullup_dis_r};
			end else if (ar_cmd == (CMD_RD_FLAG | {8'h00, IDX_GPIO_DATA})) begin
				rsp_nxt.rdata = {16'h0000, pad_in, gpio_out_r};
			end else if (ar_cmd == (CMD_RD_FLAG | {8'h00, IDX_KEY_STATE})) begin
				rsp_nxt.rdata = {16'h0000, key_state_r};
			end else begin
				rsp_nxt.rresp = RESP_SLVERR;
			end
		end
		// one write and one read in flight at most
		rsp_nxt.awready = !aw_got_nxt && !rsp_nxt.bvalid;
		rsp_nxt.wready  = !w_got_nxt && !rsp_nxt.bvalid;
		rsp_nxt.arready = !rsp_nxt.rvalid;
		// a pin drives only when set as GPIO and as output
		pad_oe_n_nxt  = ~(gpio_ctrl_nxt[GP_LSB +: 8] & gpio_ctrl_nxt[7:0]);
		pad_out_nxt   = gpio_out_nxt;
		pullup_en_nxt = ~pullup_dis_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsp_r        <= '0;
			aw_got_r     <= 1'b0;
			w_got_r      <= 1'b0;
			aw_addr_r    <= 12'h000;
			wd_r         <= 32'h0000_0000;
			ws_r         <= 4'h0;
			dbn_r        <= DBN_RST;
			hld_r        <= HLD_RST;
			mask_r       <= KEY_MASK_RST;
			gpio_ctrl_r  <= GPIO_CTRL_RST;
			pullup_dis_r <= PULLUP_RST;
			gpio_out_r   <= GPIO_OUT_RST;
			pad_out_r    <= GPIO_OUT_RST;
			pad_oe_n_r   <= 8'hFF;
			pullup_en_r  <= ~PULLUP_RST;
		end else begin
			rsp_r        <= rsp_nxt;
			aw_got_r     <= aw_got_nxt;
			w_got_r      <= w_got_nxt;
			aw_addr_r    <= aw_addr_nxt;
			wd_r         <= wd_nxt;
			ws_r         <= ws_nxt;
			dbn_r        <= dbn_nxt;
			hld_r        <= hld_nxt;
			mask_r       <= mask_nxt;
			gpio_ctrl_r  <= gpio_ctrl_nxt;
			pullup_dis_r <= pullup_dis_nxt;
			gpio_out_r   <= gpio_out_nxt;
			pad_out_r    <= pad_out_nxt;
			pad_oe_n_r   <= pad_oe_n_nxt;
			pullup_en_r  <= pullup_en_nxt;
		end
	end

	// keys whose row or column pin is GPIO cannot be seen
	assign raw_en = key_raw & key_pin_en(gpio_ctrl_r[GP_LSB +: 8]);
	assign live   = raw_en & ~mask_r;

	// debounce and hold scan
	always_comb begin
		state_nxt     = state_r;
		cnt_nxt       = cnt_r;
		rep_nxt       = rep_r;
		key_state_nxt = key_state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (|live) begin
					state_nxt = ST_DEBOUNCE;
					cnt_nxt   = dbn_cyc(dbn_r) - 32'd1;
				end
			end
			ST_DEBOUNCE: begin
				if (cnt_r != 32'd0) begin
					cnt_nxt = cnt_r - 32'd1;
				end else begin
					// masked bits keep their old value
					key_state_nxt = (key_state_r & mask_r) | live;
					if (|live) begin
						state_nxt = ST_HOLD;
						if (hld_r == 3'h0) begin
							cnt_nxt = 32'(HOLD0_CYC) - 32'd1;
							rep_nxt = 3'h0;
						end else begin
							cnt_nxt = dbn_cyc(dbn_r) - 32'd1;
							rep_nxt = hld_r - 3'd1;
						end
					end else begin
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_HOLD: begin
				if (cnt_r != 32'd0) begin
					cnt_nxt = cnt_r - 32'd1;
				end else if (rep_r != 3'h0) begin
					rep_nxt = rep_r - 3'd1;
					cnt_nxt = dbn_cyc(dbn_r) - 32'd1;
				end else begin
					state_nxt = ST_DEBOUNCE;
					cnt_nxt   = dbn_cyc(dbn_r) - 32'd1;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r     <= ST_IDLE;
			cnt_r       <= 32'd0;
			rep_r       <= 3'h0;
			key_state_r <= 16'h0000;
		end else begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			rep_r       <= rep_nxt;
			key_state_r <= key_state_nxt;
		end
	end

	a_dbn_interval_load: assert property (@(posedge aclk)
		disable iff (!aresetn)
		state_r == ST_DEBOUNCE && $past(state_r) != ST_DEBOUNCE
		|-> cnt_r == dbn_cyc($past(dbn_r)) - 32'd1)
		else $error("debounce interval load wrong");

	a_hold_zero_wait: assert property (@(posedge aclk)
		disable iff (!aresetn)
		state_r == ST_HOLD && $past(state_r) == ST_DEBOUNCE
		&& $past(hld_r) == 3'h0
		|-> cnt_r == 32'(HOLD0_CYC) - 32'd1 && rep_r == 3'h0)
		else $error("hold code zero wait wrong");

	a_hold_n_wait: assert property (@(posedge aclk)
		disable iff (!aresetn)
		state_r == ST_HOLD && $past(state_r) == ST_DEBOUNCE
		&& $past(hld_r) != 3'h0
		|-> rep_r == $past(hld_r) - 3'd1
		&& cnt_r == dbn_cyc($past(dbn_r)) - 32'd1)
		else $error("hold interval count wrong");

	a_mask_write_cmd: assert property (@(posedge aclk)
		disable iff (!aresetn)
		$rose(rsp_r.bvalid) && $past(aw_cmd) == CMD_WR_KEY_MASK
		&& $past(addr_ok(aw_addr_r)) && $past(ws_r) == 4'hF
		|-> mask_r == $past(wd_r[15:0]) && rsp_r.bresp == RESP_OKAY)
		else $error("mask write not applied");

	a_mask_read_cmd: assert property (@(posedge aclk)
		disable iff (!aresetn)
		rsp_r.arready && axil_req.arvalid && ar_cmd == CMD_RD_KEY_MASK
		&& addr_ok(axil_req.araddr)
		|=> rsp_r.rvalid && rsp_r.rdata == {16'h0000, $past(mask_r)})
		else $error("mask read data wrong");

	a_masked_key_frozen: assert property (@(posedge aclk)
		disable iff (!aresetn)
		((key_state_r ^ $past(key_state_r)) & $past(mask_r)) == 16'h0000)
		else $error("masked key changed state");

	a_key_update: assert property (@(posedge aclk)
		disable iff (!aresetn)
		state_r == ST_DEBOUNCE && cnt_r == 32'd0
		|=> key_state_r == (($past(key_state_r) & $past(mask_r))
		| ($past(raw_en) & ~$past(mask_r))))
		else $error("key state update wrong");

	a_gpio_drive: assert property (@(posedge aclk)
		disable iff (!aresetn)
		pad_oe_n == ~(gpio_ctrl_r[GP_LSB +: 8] & gpio_ctrl_r[7:0])
		&& pad_out == gpio_out_r && pullup_en == ~pullup_dis_r)
		else $error("gpio pin control wrong");

	a_ctrl_read: assert property (@(posedge aclk)
		disable iff (!aresetn)
		rsp_r.arready && axil_req.arvalid && addr_ok(axil_req.araddr)
		&& ar_cmd == (CMD_RD_FLAG | {8'h00, IDX_KPD_CTRL})
		|=> rsp_r.rdata[13:8] == {$past(dbn_r), $past(hld_r)}
		&& rsp_r.rdata[7:0] == 8'h00)
		else $error("control read fields wrong");

endmodule // kpd_debounce

// ==== design/kpd_pkg.sv ====
// package: register map, field layout, timing and bus carriers for the
// keypad debounce, hold and key mask block.
// assumes a 20 MHz aclk and an AXI4-Lite master with 12-bit byte addresses.
package kpd_pkg;

	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned CLK_PER_MS    = CLK_HZ / 1000;
	localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;

	// debounce interval per code, in ms
	localparam int unsigned DBN_MS [8]    = '{2, 10, 20, 50, 60, 80, 100, 120};
	// wait between scans for hold code zero, in us
	localparam int unsigned HOLD0_US      = 100;
	localparam int unsigned HOLD0_CYC     = HOLD0_US * CLK_PER_US;

	// register indexes; byte address is four times the index
	localparam logic [7:0]  IDX_KPD_CTRL  = 8'h41;
	localparam logic [7:0]  IDX_GPIO_DATA = 8'h4D;
	localparam logic [7:0]  IDX_PULLUP    = 8'h4E;
	localparam logic [7:0]  IDX_GPIO_CTRL = 8'h4F;
	localparam logic [7:0]  IDX_KEY_MASK  = 8'h50;
	localparam logic [7:0]  IDX_KEY_STATE = 8'h52;
	localparam logic [15:0] CMD_RD_FLAG   = 16'h8000;
	localparam logic [15:0] CMD_WR_KEY_MASK = 16'h0050;
	localparam logic [15:0] CMD_RD_KEY_MASK = 16'h8050;

	// keypad and GPIO control fields
	localparam int          KST_PRESS_BIT = 15;
	localparam int          KST_IDLE_BIT  = 14;
	localparam int          DBN_LSB       = 11;
	localparam int          HLD_LSB       = 8;
	localparam int          GP_LSB        = 8;

	// values after reset
	localparam logic [2:0]  DBN_RST       = 3'h0;
	localparam logic [2:0]  HLD_RST       = 3'h0;
	localparam logic [15:0] KEY_MASK_RST  = 16'h0000;
	localparam logic [15:0] GPIO_CTRL_RST = 16'h0000;
	localparam logic [7:0]  PULLUP_RST    = 8'h00;
	localparam logic [7:0]  GPIO_OUT_RST  = 8'h00;

	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b001,
		ST_DEBOUNCE = 3'b010,
		ST_HOLD     = 3'b100
	} scan_e;

	typedef struct packed {
		logic        awvalid;
		logic [11:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [11:0] araddr;
		logic        rready;
	} axil_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_s;

endpackage

// ==== sim/key_matrix.sv ====
// partner model: key switch contacts and the eight pad lines
// assumes press is moved by the bench just after a rising edge of aclk
`timescale 1ns/1ps
module key_matrix (
	input  wire logic        aclk,
	input  wire logic [15:0] press,
	input  wire logic [7:0]  pad_out,
	input  wire logic [7:0]  pad_oe_n,
	input  wire logic [7:0]  pullup_en,
	output logic      [15:0] key_raw,
	output logic      [7:0]  pad_in
);
	logic [7:0] float_r;

	initial float_r = 8'h55;
	// contacts settle one cycle after the bench moves a key
	always @(posedge aclk) key_raw <= press;
	// an undriven line without pull-up keeps no level, so it toggles
	always @(posedge aclk) float_r <= ~float_r;
	assign pad_in = (~pad_oe_n & pad_out)
		| (pad_oe_n & (pullup_en | float_r));
endmodule // key_matrix

// ==== sim/testbench.sv ====
// testbench: bus master, key presses and result checks for kpd_debounce
// assumes the key_matrix partner model and the kpd_pkg package
`timescale 1ns/1ps
module testbench;
	import kpd_pkg::*;
	localparam int CYC = 4;
	localparam int U1  = DBN_MS[1] * CYC;
	logic        aclk;
	logic        aresetn;
	axil_req_s   req;
	axil_rsp_s   rsp;
	logic [15:0] press;
	logic [15:0] key_raw;
	logic [7:0]  pad_in;
	logic [7:0]  pad_out;
	logic [7:0]  pad_oe_n;
	logic [7:0]  pullup_en;
	logic [15:0] key_state;
	logic [34:0] rq[$];
	logic [1:0]  bq[$];
	int          n_fail;
	int          total_checks;
	int          t[8];
	logic [15:0] m1;
	logic [15:0] p1;
	logic [15:0] p2;

	kpd_debounce #(.CYC_PER_MS(CYC)) DUT (.aclk(aclk), .aresetn(aresetn),
		.axil_req(req), .axil_rsp(rsp), .key_raw(key_raw),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.pullup_en(pullup_en), .key_state(key_state));
	key_matrix u_keys (.aclk(aclk), .press(press), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .pullup_en(pullup_en), .key_raw(key_raw),
		.pad_in(pad_in));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h, want %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic do_reset;
		aresetn <= 1'b0;
		press   <= 16'h0000;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	// the first edge only lets the previous release land
	task automatic wr(input logic [11:0] a, input logic [15:0] d,
		input logic [1:0] e);
		bq.push_back(e);
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= {16'h0000, d};
		req.wstrb   <= 4'hF;
		req.bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		req.bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [15:0] d,
		input logic [1:0] e);
		rq.push_back({e == RESP_OKAY, e, 16'h0000, d});
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		req.rready <= 1'b0;
	endtask

	// counts edges until key_state moves; the bias cancels in differences
	task automatic wait_ks(output int n);
		logic [15:0] old;
		old = key_state;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (key_state === old && n < 5000);
	endtask

	always @(posedge aclk) begin
		if (rsp.rvalid && req.rready && rq.size() > 0) begin
			check(32'(rsp.rresp), 32'(rq[0][33:32]));
			if (rq[0][34]) check(rsp.rdata, rq[0][31:0]);
			void'(rq.pop_front());
		end
		if (rsp.bvalid && req.bready && bq.size() > 0)
			check(32'(rsp.bresp), 32'(bq.pop_front()));
	end

	initial begin
		int u;
		req = '0;
		aresetn = 1'b0;
		press = '0;
		n_fail = 0;
		total_checks = 0;
		void'($urandom(47));
		@(posedge aclk);
		do_reset;
		rd(ba(IDX_KEY_MASK), 16'h0000, RESP_OKAY);
		check(32'(pad_oe_n), 32'hFF);
		check(32'(pullup_en), 32'hFF);
		check(32'(key_state), 32'h0);
		for (int c = 0; c < 8; c++) begin
			do_reset;
			wr(ba(IDX_KPD_CTRL), {2'b00, 3'(c), 3'd1, 8'h00}, RESP_OKAY);
			rd(ba(IDX_KPD_CTRL), {2'b01, 3'(c), 3'd1, 8'h00}, RESP_OKAY);
			press <= 16'h0001;
			wait_ks(t[c]);
			check(32'(t[c] - t[0]), 32'((DBN_MS[c] - DBN_MS[0]) * CYC));
		end
		// second key joins while the first is held, timing the hold wait
		for (int h = 0; h < 8; h++) begin
			do_reset;
			wr(ba(IDX_KPD_CTRL), {2'b00, 3'd1, 3'(h), 8'h00}, RESP_OKAY);
			press <= 16'h0001;
			wait_ks(u);
			press <= 16'h0003;
			wait_ks(t[h]);
		end
		// expectations come from the interval length, not from a measurement
		check(32'(t[2] - t[1]), 32'(U1));
		for (int h = 3; h < 8; h++) begin
			check(32'(t[h] - t[1]), 32'((h - 1) * U1));
		end
		check(32'(t[0] - t[1] + U1), 32'(HOLD0_CYC));
		do_reset;
		wr(ba(IDX_KPD_CTRL), 16'h0100, RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			m1 = (i == 0) ? 16'h8000 : 16'($urandom) & 16'hFFFE;
			p1 = (i == 0) ? 16'hFFFF : 16'($urandom) | 16'h0001;
			p2 = (i == 0) ? 16'h0001 : 16'($urandom) | 16'h0001;
			wr(ba(IDX_KEY_MASK), 16'h0000, RESP_OKAY);
			press <= p1;
			repeat (40) @(posedge aclk);
			check(32'(key_state), 32'(p1));
			wr(ba(IDX_KEY_MASK), m1, RESP_OKAY);
			rd(ba(IDX_KEY_MASK), m1, RESP_OKAY);
			press <= p2;
			repeat (40) @(posedge aclk);
			check(32'(key_state), 32'((p2 & ~m1) | (p1 & m1)));
		end
		rd(12'h141, 16'h0000, RESP_SLVERR);
		rd(ba(8'h51), 16'h0000, RESP_SLVERR);
		wr(ba(IDX_KEY_STATE), 16'h0000, RESP_OKAY);
		rd(ba(IDX_KEY_STATE), (p2 & ~m1) | (p1 & m1), RESP_OKAY);
		press <= 16'h0000;
		wr(ba(IDX_GPIO_CTRL), 16'h0101, RESP_OKAY);
		wr(ba(IDX_GPIO_DATA), 16'h005A, RESP_OKAY);
		check(32'(pad_oe_n), 32'hFE);
		rd(ba(IDX_GPIO_DATA), 16'hFE5A, RESP_OKAY);
		check(32'(pad_out), 32'h5A);
		wr(ba(IDX_PULLUP), 16'h00F0, RESP_OKAY);
		@(posedge aclk);
		check(32'(pullup_en), 32'h0F);
		// row 1 now serves as a gpio pin, so keys 0, 4, 8 and 12 stay unseen
		wr(ba(IDX_KEY_MASK), 16'h0000, RESP_OKAY);
		press <= 16'hFFFF;
		repeat (40) @(posedge aclk);
		check(32'(key_state), 32'hEEEE);
		print_verdict;
	end

	// the whole run needs some 6000 cycles
	initial begin
		repeat (40000) @(posedge aclk);
		n_fail++;
		print_verdict;
	end
endmodule // testbench
